// ---- design/dcd_pkg.sv ----
// Shared constants for the DRAM configuration and decode front end.
// Assumes a single 25 MHz clock domain and byte-wide port accesses.
package dcd_pkg;
  localparam logic [7:0] IDX_PORT      = 8'h22;
  localparam logic [7:0] DATA_PORT     = 8'h23;
  localparam logic [7:0] REG0_INDEX    = 8'h00;
  localparam logic [7:0] REG1_INDEX    = 8'h01;
  localparam logic [7:0] REG0_RESET    = 8'h00;
  localparam logic [7:0] REG1_RESET    = 8'h00;
  localparam logic [7:0] REG1_MASK     = 8'h0F;
  localparam logic [7:0] INDEX_RESET   = 8'h00;
  localparam int BIT_TYPE_1M   = 7;
  localparam int BIT_TO_DIS    = 6;
  localparam int BIT_BANK23    = 5;
  localparam int BIT_RELOC_LOW = 4;
  localparam int BIT_RDONLY    = 3;
  localparam int BIT_MAP_EN    = 2;
  localparam int BIT_BASE_640  = 1;
  localparam int BIT_ILEAVE    = 0;
  localparam int BIT_PRE_HI    = 3;
  localparam int BIT_ZWS_HI    = 2;
  localparam int BIT_PRE_LO    = 1;
  localparam int BIT_ZWS_LO    = 0;
  localparam logic [3:0] PRE_SLOW = 4'h6;
  localparam logic [3:0] PRE_FAST = 4'h4;
  localparam int CLOCK_MHZ     = 25;
  localparam int RAS_TIMEOUT_US = 10;
  localparam int RAS_TIMEOUT_CYC = RAS_TIMEOUT_US * CLOCK_MHZ;
  localparam logic [23:0] BASE_512   = 24'h080000;
  localparam logic [23:0] BASE_640   = 24'h0A0000;
  localparam logic [23:0] MEG_ONE    = 24'h100000;
  localparam logic [23:0] REMAP_TOP  = 24'hFE0000;
  localparam logic [23:0] BIOS_HI    = 24'hFE0000;
  localparam logic [23:0] BIOS_LO    = 24'h0E0000;
  localparam logic [23:0] BIOS_SIZE  = 24'h020000;
  localparam logic [23:0] SIZE_256K_1 = 24'h100000;
  localparam logic [23:0] SIZE_1M_1   = 24'h400000;
endpackage : dcd_pkg

// ---- design/dcd_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
module dcd_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dcd_sync_type;
  dcd_sync_type st;
  dcd_sync_type next_st;

  // The first stage feeds only the second; the filter looks at two and three.
  always_comb begin
    next_st     = st;
    next_st.s1  = i_async;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end

  // Registers take constants only under reset.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.lvl;
endmodule : dcd_sync

// ---- design/dcd_top.sv ----
// DRAM controller configuration registers, address decode and bank strobes.
// Assumes pin inputs are asynchronous; select, read, write, address strobe and cycle end pass through dcd_sync first.
`timescale 1ns/1ps
module dcd_top (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_port_pair_select_n,
  input  wire logic        i_io_read_n,
  input  wire logic        i_io_write_n,
  input  wire logic [1:0]  i_sys_addr_low,
  input  wire logic [7:0]  i_muxed_addr_data,
  input  wire logic        i_mode_paged,
  input  wire logic        i_addr_strobe_n,
  input  wire logic        i_write_cycle,
  input  wire logic        i_cycle_end,
  input  wire logic [23:2] i_local_addr,
  output logic             o_cfg_buffer_enable_n,
  output logic [7:0]       o_muxed_addr_data,
  output logic [7:0]       o_muxed_addr_data_oe,
  output logic             o_dram_addr_bit8,
  output logic             o_dram_addr_bit9,
  output logic [3:0]       o_bank_row_strobe_n,
  output logic [3:0]       o_bank_col_strobe_n,
  output logic             o_read_zero_wait,
  output logic             o_direct_mode
);
  typedef enum { S_IDLE, S_ROW, S_COL, S_PRE } dcd_state_type;

  typedef struct packed {
    logic [7:0]    index;
    logic [7:0]    reg0;
    logic [7:0]    reg1;
    logic          io_busy;
    logic [7:0]    rd_data;
    logic          rd_drive;
    logic          den_n;
    logic [23:2]   addr;
    logic          wr;
    dcd_state_type state;
    logic [3:0]    bank;
    logic [3:0]    ras_n;
    logic [3:0]    cas_n;
    logic [8:0]    ras_cnt;
    logic [3:0]    pre_cnt;
    logic [9:0]    ma;
    logic          zws;
  } dcd_top_type;

  dcd_top_type st;
  dcd_top_type next_st;

  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ads_n;
  logic cyc_end;

  // Select, read, write, address strobe and cycle end each go through a three-stage filter.
  dcd_sync #(.RESET_VALUE(1'b1)) u_cs (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_async(i_port_pair_select_n), .o_level(cs_n));
  dcd_sync #(.RESET_VALUE(1'b1)) u_rd (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_async(i_io_read_n), .o_level(rd_n));
  dcd_sync #(.RESET_VALUE(1'b1)) u_wr (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_async(i_io_write_n), .o_level(wr_n));
  dcd_sync #(.RESET_VALUE(1'b1)) u_ads (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_async(i_addr_strobe_n), .o_level(ads_n));
  dcd_sync #(.RESET_VALUE(1'b0)) u_end (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_async(i_cycle_end), .o_level(cyc_end));

  logic        cfg_cycle;
  logic        cfg_start;
  logic        is_data;
  logic        hit_dram;
  logic        hit_bios;
  logic [23:0] full_addr;
  logic [23:0] top_size;
  logic [23:0] base_top;
  logic [3:0]  bank_sel;
  logic [3:0]  bank_allow;
  logic [3:0]  pre_len;

  // A config cycle needs chip select and one command at once.
  assign cfg_cycle = !cs_n && (!rd_n || !wr_n);
  localparam logic [1:0] DATA_PORT_LOW = dcd_pkg::DATA_PORT[1:0];
  assign cfg_start = cfg_cycle && !st.io_busy;
  assign is_data   = (i_sys_addr_low == DATA_PORT_LOW);

  // Address decode follows the live register settings.
  always_comb begin
    full_addr = {st.addr, 2'b00};
    base_top  = st.reg0[dcd_pkg::BIT_BASE_640] ? dcd_pkg::BASE_640
                                               : dcd_pkg::BASE_512;
    top_size  = st.reg0[dcd_pkg::BIT_TYPE_1M] ? dcd_pkg::SIZE_1M_1
                                              : dcd_pkg::SIZE_256K_1;
    hit_bios  = st.reg0[dcd_pkg::BIT_RELOC_LOW] ?
      (full_addr >= dcd_pkg::BIOS_LO &&
       full_addr < dcd_pkg::BIOS_LO + dcd_pkg::BIOS_SIZE) :
      (full_addr >= dcd_pkg::BIOS_HI);
    hit_dram  = (full_addr < base_top) ||
      (full_addr >= dcd_pkg::MEG_ONE && full_addr < top_size) ||
      (st.reg0[dcd_pkg::BIT_MAP_EN] && hit_bios) ||
      (st.reg0[dcd_pkg::BIT_MAP_EN] &&
       full_addr >= dcd_pkg::REMAP_TOP - (dcd_pkg::MEG_ONE - base_top) &&
       full_addr < dcd_pkg::REMAP_TOP);
    if (st.wr && hit_bios && st.reg0[dcd_pkg::BIT_RDONLY]) begin
      hit_dram = 1'b0;
    end
  end

  // Bank choice: page bit picks even or odd bank when interleaved.
  always_comb begin
    bank_allow = st.reg0[dcd_pkg::BIT_BANK23] ? 4'hF : 4'h3;
    bank_sel   = 4'h1;
    if (st.reg0[dcd_pkg::BIT_ILEAVE]) begin
      if (st.reg0[dcd_pkg::BIT_BANK23]) begin
        bank_sel = 4'h1 << {st.addr[13], st.addr[12]};
      end else begin
        bank_sel = st.addr[12] ? 4'h2 : 4'h1;
      end
    end
    bank_sel = bank_sel & bank_allow;
    pre_len  = (bank_sel[3:2] != 2'b00) ?
      (st.reg1[dcd_pkg::BIT_PRE_HI] ? dcd_pkg::PRE_FAST : dcd_pkg::PRE_SLOW) :
      (st.reg1[dcd_pkg::BIT_PRE_LO] ? dcd_pkg::PRE_FAST
                                    : dcd_pkg::PRE_SLOW);
  end

  // Next-state logic for the port pair and the strobe sequencer.
  always_comb begin
    next_st         = st;
    next_st.io_busy = cfg_cycle;
    next_st.den_n   = !cfg_cycle;
    next_st.rd_drive = cfg_cycle && !rd_n && is_data;
    // Write data is taken only once the pins are released to the host.
    // On the first cycle the pins still drive the DRAM address.
    if (cfg_cycle && st.io_busy && !wr_n) begin
      if (!is_data) begin
        next_st.index = i_muxed_addr_data;
      end else if (st.index == dcd_pkg::REG0_INDEX) begin
        next_st.reg0 = i_muxed_addr_data;
      end else if (st.index == dcd_pkg::REG1_INDEX) begin
        next_st.reg1 = i_muxed_addr_data & dcd_pkg::REG1_MASK;
      end
      // Other indices fall through untouched.
    end
    if (cfg_start && !rd_n) begin
      next_st.rd_data = (st.index == dcd_pkg::REG0_INDEX) ? st.reg0 :
                        (st.index == dcd_pkg::REG1_INDEX) ? st.reg1 : 8'h00;
    end
    next_st.zws = (bank_sel[3:2] != 2'b00) ? st.reg1[dcd_pkg::BIT_ZWS_HI]
                                           : st.reg1[dcd_pkg::BIT_ZWS_LO];
    case (st.state)
      S_IDLE: begin
        next_st.ras_n = 4'hF;
        next_st.cas_n = 4'hF;
        if (!ads_n) begin
          next_st.addr  = i_local_addr;
          next_st.wr    = i_write_cycle;
          next_st.state = S_ROW;
        end
      end
      S_ROW: begin
        if (hit_dram && bank_sel != 4'h0) begin
          next_st.bank    = bank_sel;
          next_st.ras_n   = ~bank_sel;
          next_st.ras_cnt = 9'h000;
          next_st.ma      = st.addr[21:12];
          next_st.state   = S_COL;
        end else begin
          next_st.state = cyc_end ? S_IDLE : S_ROW;
        end
      end
      S_COL: begin
        next_st.cas_n   = ~st.bank;
        next_st.ma      = {1'b0, st.addr[10:2]};
        next_st.ras_cnt = st.ras_cnt + 9'h001;
        if (cyc_end || (!st.reg0[dcd_pkg::BIT_TO_DIS] &&
            st.ras_cnt == 9'(dcd_pkg::RAS_TIMEOUT_CYC - 1))) begin
          next_st.ras_n   = 4'hF;
          next_st.cas_n   = 4'hF;
          next_st.pre_cnt = pre_len;
          next_st.state   = S_PRE;
        end
      end
      S_PRE: begin
        next_st.pre_cnt = st.pre_cnt - 4'h1;
        if (st.pre_cnt <= 4'h1 && !cyc_end) begin
          next_st.state = S_IDLE;
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
  end

  // State register; reset restores defaults and clears the index.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st       <= '0;
      st.index <= dcd_pkg::INDEX_RESET;
      st.reg0  <= dcd_pkg::REG0_RESET;
      st.reg1  <= dcd_pkg::REG1_RESET;
      st.den_n <= 1'b1;
      st.ras_n <= 4'hF;
      st.cas_n <= 4'hF;
      st.state <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Pins carry read data during data-port config reads, are released in other busy config cycles, and carry DRAM address otherwise.
  assign o_muxed_addr_data    = st.rd_drive ? st.rd_data : st.ma[7:0];
  assign o_muxed_addr_data_oe = (st.rd_drive || st.io_busy == 1'b0) ?
                                8'hFF : 8'h00;
  assign o_dram_addr_bit8      = st.ma[8];
  assign o_dram_addr_bit9      = st.ma[9];
  assign o_cfg_buffer_enable_n = st.den_n;
  assign o_bank_row_strobe_n   = st.ras_n;
  assign o_bank_col_strobe_n   = st.cas_n;
  assign o_read_zero_wait      = st.zws;
  assign o_direct_mode         = !i_mode_paged;

  // Checks.
  a_den_follows_cs: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cfg_cycle |=> !o_cfg_buffer_enable_n) else $error("den not low");
  a_den_idle_high: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !cfg_cycle |=> o_cfg_buffer_enable_n) else $error("den stuck");
  a_index_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cfg_cycle && st.io_busy && !wr_n && !is_data |=>
    st.index == $past(i_muxed_addr_data))
    else $error("index not stored");
  a_upper_banks: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !st.reg0[dcd_pkg::BIT_BANK23] |-> o_bank_row_strobe_n[3:2] == 2'b11)
    else $error("upper bank strobed");
  a_ras_timeout: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !st.reg0[dcd_pkg::BIT_TO_DIS] |-> st.ras_cnt <= 9'(dcd_pkg::RAS_TIMEOUT_CYC))
    else $error("ras too long");
  a_read_drive: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.rd_drive |-> o_muxed_addr_data_oe == 8'hFF) else $error("no drive");
  a_reg1_reserved: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.reg1[7:4] == 4'h0) else $error("reserved set");
  sequence s_col_then_pre;
    st.state == S_COL ##1 st.state == S_PRE;
  endsequence
  a_pre_high: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_col_then_pre |-> o_bank_row_strobe_n == 4'hF) else $error("pre low");
  a_ileave_even: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.state == S_COL && st.reg0[dcd_pkg::BIT_ILEAVE] &&
    !st.reg0[dcd_pkg::BIT_BANK23] |-> st.bank[1] == st.addr[12])
    else $error("wrong bank");
  a_addr_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.state == S_COL |=> st.addr == $past(st.addr))
    else $error("addr moved");
endmodule : dcd_top

// ---- tb/dcd_bank_model.sv ----
// Far-side model: four DRAM banks and the pulled-up muxed data pins.
// Assumes the bench clears the record before each memory cycle.
`timescale 1ns/1ps
module dcd_bank_model (
  input  wire logic       i_clock,
  input  wire logic       i_clear,
  input  wire logic [3:0] i_row_n,
  input  wire logic [3:0] i_col_n,
  input  wire logic [7:0] i_dev_data,
  input  wire logic [7:0] i_dev_oe,
  input  wire logic       i_host_drive,
  input  wire logic [7:0] i_host_data,
  output logic [3:0]      o_seen,
  output logic            o_col_fault,
  output logic [7:0]      o_wire
);
  logic [3:0] col_q;

  // Released pins carry host data while the host drives, else float high through the pull-ups, never to a stale value.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_dev_oe[b]) o_wire[b] = i_dev_data[b];
      else if (i_host_drive) o_wire[b] = i_host_data[b];
      else o_wire[b] = 1'b1;
    end
  end

  // A bank only latches a column after its row strobe has fallen.
  always_ff @(posedge i_clock) begin
    col_q <= i_col_n;
    if (i_clear) begin
      o_seen      <= 4'h0;
      o_col_fault <= 1'b0;
    end else begin
      o_seen <= o_seen | ~i_row_n;
      if (|(~i_col_n & col_q & i_row_n)) o_col_fault <= 1'b1;
    end
  end
endmodule : dcd_bank_model

// ---- tb/tb.sv ----
// Self-checking bench: port-pair register access and bank strobe checks.
// Assumes inputs pass a three-stage synchroniser, so requests are held long.
`timescale 1ns/1ps
module tb;
  logic        i_clock, i_sys_rst, cs_n, rd_n, wr_n, mode, ads_n, cend;
  logic        drv, clr, den_n, a8, a9, zw, direct, cas_bad;
  logic [1:0]  alow;
  logic [23:2] laddr;
  logic [7:0]  wdata, dout, doe, wire_lvl, q;
  logic [3:0]  ras_n, cas_n, seen;
  int          failures, samples_checked;

  dcd_top u_dcd_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_port_pair_select_n(cs_n), .i_io_read_n(rd_n), .i_io_write_n(wr_n),
    .i_sys_addr_low(alow), .i_muxed_addr_data(wire_lvl),
    .i_mode_paged(mode), .i_addr_strobe_n(ads_n), .i_write_cycle(1'b0),
    .i_cycle_end(cend), .i_local_addr(laddr),
    .o_cfg_buffer_enable_n(den_n), .o_muxed_addr_data(dout),
    .o_muxed_addr_data_oe(doe), .o_dram_addr_bit8(a8),
    .o_dram_addr_bit9(a9), .o_bank_row_strobe_n(ras_n),
    .o_bank_col_strobe_n(cas_n), .o_read_zero_wait(zw),
    .o_direct_mode(direct));

  dcd_bank_model u_dcd_bank_model (.i_clock(i_clock), .i_clear(clr),
    .i_row_n(ras_n), .i_col_n(cas_n), .i_dev_data(dout), .i_dev_oe(doe),
    .i_host_drive(drv), .i_host_data(wdata), .o_seen(seen),
    .o_col_fault(cas_bad), .o_wire(wire_lvl));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One port cycle; command, select and data held well past the filter.
  task automatic io(input logic wr, input logic [1:0] a, input logic [7:0] d,
                    input logic sel);
    @(negedge i_clock);
    cs_n  = ~sel;
    alow  = a;
    wdata = d;
    drv   = wr;
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (8) @(negedge i_clock);
    q = wire_lvl;
    chk({7'h00, den_n}, {7'h00, ~sel});
    chk(doe, (sel && wr) ? 8'h00 : 8'hFF);
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge i_clock);
    cs_n = 1'b1;
    drv  = 1'b0;
    repeat (4) @(negedge i_clock);
  endtask : io

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, 2'h0, idx, 1'b1);
    io(1'b1, 2'h3, d, 1'b1);
  endtask : wreg

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, 2'h0, idx, 1'b1);
    io(1'b0, 2'h3, 8'h00, 1'b1);
    chk(q, exp);
  endtask : rreg

  // Memory cycle; the address changes after the strobe to prove the latch.
  task automatic mem(input logic [23:0] a, input logic [3:0] exp,
                     input logic hold);
    int n;
    n = 0;
    @(negedge i_clock);
    clr   = 1'b1;
    laddr = a[23:2];
    ads_n = 1'b0;
    repeat (6) @(negedge i_clock);
    clr   = 1'b0;
    ads_n = 1'b1;
    laddr = ~a[23:2];
    while (cas_n === 4'hF && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk({4'h0, ras_n}, {4'h0, exp});
    chk({4'h0, cas_n}, {4'h0, exp});
    chk({7'h00, zw}, 8'h01);
    n = 0;
    if (hold) begin
      while (ras_n !== 4'hF && n < 300) begin
        @(negedge i_clock);
        n++;
      end
      chk({4'h0, ras_n}, 8'h0F);
    end
    cend = 1'b1;
    n = 0;
    while (ras_n !== 4'hF && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    cend = 1'b0;
    chk({4'h0, seen}, {4'h0, ~exp});
    chk({7'h00, cas_bad}, 8'h00);
    repeat (12) @(negedge i_clock);
  endtask : mem

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short; the whole sequence needs well under 5000 cycles.
  initial begin
    #(40 * 20000);
    failures++;
    report_and_stop();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    {cs_n, rd_n, wr_n, ads_n} = 4'hF;
    {mode, cend, drv, clr} = 4'h0;
    alow = 2'h0;
    wdata = 8'h00;
    laddr = '0;
    i_sys_rst = 1'b1;
    repeat (16) @(negedge i_clock);
    i_sys_rst = 1'b0;
    repeat (6) @(negedge i_clock);
    chk({7'h00, den_n}, 8'h01);
    chk({7'h00, direct}, 8'h01);
    mode = 1'b1;
    @(negedge i_clock);
    chk({7'h00, direct}, 8'h00);
    rreg(8'h00, 8'h00);
    rreg(8'h01, 8'h00);
    $display("test reset defaults done");
    wreg(8'h00, 8'hA5);
    rreg(8'h00, 8'hA5);
    wreg(8'h01, 8'hFF);
    rreg(8'h01, 8'h0F);
    wreg(8'h07, 8'h33);
    rreg(8'h07, 8'h00);
    rreg(8'h00, 8'hA5);
    io(1'b1, 2'h3, 8'h00, 1'b0);
    rreg(8'h01, 8'h0F);
    $display("test register access done");
    wreg(8'h00, 8'h00);
    mem(24'h000000, 4'hE, 1'b0);
    mem(24'h000000, 4'hE, 1'b1);
    $display("test single bank done");
    wreg(8'h01, 8'h05);
    wreg(8'h00, 8'h01);
    mem(24'h000000, 4'hE, 1'b0);
    mem(24'h001800, 4'hD, 1'b0);
    wreg(8'h00, 8'h21);
    mem(24'h002000, 4'hB, 1'b0);
    $display("test interleave done");
    report_and_stop();
  end
endmodule : tb
